/* File: common/adsr_params.svh */
// register map, field positions and codes of the data/status register bank
// Functional notes
// - fast-read burst skips low sample bytes, returning high bytes only
// - normal burst returns X high, X low, Y high, Y low, Z high, Z low
// - sample bytes sit at 0x01..0x06 right after the status register
// - 10-bit two's complement; high holds bits 9..2, low bits 1..0 on top
// - low byte readable only straight after its high byte
// - high byte read captures paired low byte for the following low read
// - combined overwrite sets on overrun, clears after all three highs read
// - per-axis overwrite sets on unread overrun, clears on that high read
// - combined ready sets on any new sample, clears after all highs read
// - per-axis ready sets on new sample, clears on that high read
// - operating state: 00 standby, 01 wake, 10 sleep; upper bits zero
// - event bits set on rising condition, cleared by reading the register each one is tied to
// - sample-ready event from ready or overwrite; cleared by reading three highs
// - sleep/wake event sets on a wake-to-sleep or sleep-to-wake transition, clears on operating-state read
// - sleep after inactivity limit exceeded, wake again on wake event
// - orientation event follows changed flag; cleared by orientation status read
// - motion event follows active flag; cleared by motion source read
// - read-only part identifier at 0x0D, writes ignored
// - standby-to-active clears samples, status and events; kept otherwise
`ifndef ADSR_PARAMS_SVH
`define ADSR_PARAMS_SVH

`define ADSR_ADDR_STATUS 8'h00
`define ADSR_ADDR_X_HI 8'h01
`define ADSR_ADDR_X_LO 8'h02
`define ADSR_ADDR_Y_HI 8'h03
`define ADSR_ADDR_Y_LO 8'h04
`define ADSR_ADDR_Z_HI 8'h05
`define ADSR_ADDR_Z_LO 8'h06
`define ADSR_ADDR_OPSTATE 8'h0B
`define ADSR_ADDR_EVSRC 8'h0C
`define ADSR_ADDR_PART_ID 8'h0D
`define ADSR_ADDR_ORIENT_ST 8'h10
`define ADSR_ADDR_MOTION_SRC 8'h16
`define ADSR_ADDR_STEP 8'h01

// arbitrary neutral identifier value
`define ADSR_PART_ID 8'hC3

`define ADSR_EV_DRDY 0
`define ADSR_EV_MOTION 2
`define ADSR_EV_ORIENT 4
`define ADSR_EV_SLEEP 7

`define ADSR_MODE_STANDBY 2'h0
`define ADSR_MODE_WAKE 2'h1
`define ADSR_MODE_SLEEP 2'h2

`define ADSR_SAMPLE_W 10
`define ADSR_LOW_PAD 6'h00
`define ADSR_LIMIT_W 8
`define ADSR_AXES 3
`define ADSR_ALL_AXES 3'h7

`endif

/* File: common/adsr_pkg.sv */
// state type of the sleep/wake controller
package adsr_pkg;
  typedef enum logic [2:0] {
    ADSR_ST_STANDBY = 3'h1,
    ADSR_ST_WAKE = 3'h2,
    ADSR_ST_SLEEP = 3'h4
  } adsr_state_t;
endpackage

/* File: verilog/adsr_axis.sv */
// one axis: sample hold, paired low capture, ready and overwrite flags
`timescale 1ns/1ps
`default_nettype none
`include "adsr_params.svh"
module adsr_axis (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic new_sample,
  input wire logic [`ADSR_SAMPLE_W-1:0] sample_in,
  input wire logic high_read,
  output logic [7:0] high_byte,
  output logic [7:0] low_byte,
  output logic ready,
  output logic overwrite,
  output logic overrun
);
  logic [`ADSR_SAMPLE_W-1:0] sample_q, sample_d;
  logic [7:0] low_hold_q, low_hold_d;
  logic ready_q, ready_d;
  logic over_q, over_d;

  // next sample, paired low byte and flags; a clear wins over a new sample
  always_comb begin
    sample_d = sample_q;
    low_hold_d = low_hold_q;
    ready_d = ready_q;
    over_d = over_q;
    overrun = new_sample && ready_q && !high_read;
    if (high_read) begin
      low_hold_d = {sample_q[1:0], `ADSR_LOW_PAD};
      ready_d = 1'h0;
      over_d = 1'h0;
    end
    if (new_sample) begin
      sample_d = sample_in;
      ready_d = 1'h1;
    end
    if (overrun) begin
      over_d = 1'h1;
    end
    if (clear) begin
      sample_d = '0;
      low_hold_d = 8'h00;
      ready_d = 1'h0;
      over_d = 1'h0;
    end
  end

  // register the axis state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sample_q <= '0;
      low_hold_q <= 8'h00;
      ready_q <= 1'h0;
      over_q <= 1'h0;
    end else begin
      sample_q <= sample_d;
      low_hold_q <= low_hold_d;
      ready_q <= ready_d;
      over_q <= over_d;
    end
  end

  // high byte carries bits 9..2
  assign high_byte = sample_q[`ADSR_SAMPLE_W-1:2];
  assign low_byte = low_hold_q;
  assign ready = ready_q;
  assign overwrite = over_q;
endmodule // adsr_axis
`default_nettype wire

/* File: verilog/adsr_sleep.sv */
// operating-state controller: standby, wake and sleep with inactivity count
`timescale 1ns/1ps
`default_nettype none
`include "adsr_params.svh"
module adsr_sleep #(
  parameter int LIMIT_W = `ADSR_LIMIT_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic active,
  input wire logic sleep_enable,
  input wire logic [LIMIT_W-1:0] inactivity_limit,
  input wire logic time_tick,
  input wire logic any_event,
  input wire logic wake_event,
  output logic [1:0] mode,
  output logic transition,
  output logic low_rate
);
  adsr_pkg::adsr_state_t state_q, state_d;
  logic [LIMIT_W-1:0] count_q, count_d;
  logic trans_q, trans_d;

  // state, inactivity count and transition pulse
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    trans_d = 1'h0;
    unique case (state_q)
      adsr_pkg::ADSR_ST_STANDBY: begin
        count_d = '0;
        if (active) begin
          state_d = adsr_pkg::ADSR_ST_WAKE;
        end
      end
      adsr_pkg::ADSR_ST_WAKE: begin
        if (any_event || !sleep_enable) begin
          count_d = '0;
        end else if (count_q > inactivity_limit) begin
          state_d = adsr_pkg::ADSR_ST_SLEEP;
          trans_d = 1'h1;
          count_d = '0;
        end else if (time_tick && count_q != '1) begin
          count_d = LIMIT_W'(count_q + 1'h1);
        end
      end
      adsr_pkg::ADSR_ST_SLEEP: begin
        if (wake_event) begin
          state_d = adsr_pkg::ADSR_ST_WAKE;
          trans_d = 1'h1;
        end
      end
      default: begin
        state_d = adsr_pkg::ADSR_ST_STANDBY;
      end
    endcase
    if (!active) begin
      state_d = adsr_pkg::ADSR_ST_STANDBY;
      trans_d = 1'h0;
    end
  end

  // register controller state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= adsr_pkg::ADSR_ST_STANDBY;
      count_q <= '0;
      trans_q <= 1'h0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      trans_q <= trans_d;
    end
  end

  // mode code for the operating-state register
  always_comb begin
    unique case (state_q)
      adsr_pkg::ADSR_ST_WAKE: mode = `ADSR_MODE_WAKE;
      adsr_pkg::ADSR_ST_SLEEP: mode = `ADSR_MODE_SLEEP;
      default: mode = `ADSR_MODE_STANDBY;
    endcase
  end

  assign transition = trans_q;
  assign low_rate = (state_q == adsr_pkg::ADSR_ST_SLEEP);
endmodule // adsr_sleep
`default_nettype wire

/* File: verilog/adsr_regs.sv */
// data, status, operating-state, event-source and identifier register bank
`timescale 1ns/1ps
`default_nettype none
`include "adsr_params.svh"
module adsr_regs #(
  parameter int LIMIT_W = `ADSR_LIMIT_W
) (
  input wire logic clock,
  input wire logic rst_n,
  // control bits from the control register block
  input wire logic active,
  input wire logic fast_read,
  input wire logic sleep_enable,
  input wire logic [LIMIT_W-1:0] inactivity_limit,
  input wire logic drdy_enable,
  input wire logic motion_enable,
  input wire logic orient_enable,
  // time base and wake source from the detectors
  input wire logic time_tick,
  input wire logic wake_event,
  // new samples, one strobe per axis (0 x, 1 y, 2 z)
  input wire logic [`ADSR_AXES-1:0] sample_strobe,
  input wire logic [`ADSR_SAMPLE_W-1:0] x_sample,
  input wire logic [`ADSR_SAMPLE_W-1:0] y_sample,
  input wire logic [`ADSR_SAMPLE_W-1:0] z_sample,
  // detector flags
  input wire logic orientation_changed,
  input wire logic motion_active,
  // byte port from the serial protocol engine
  input wire logic addr_load,
  input wire logic [7:0] addr_in,
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic [7:0] ext_rd_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [7:0] rd_addr,
  output logic [1:0] operating_state,
  output logic low_rate,
  output logic event_pending
);
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d;
  logic [7:0] rd_addr_q, rd_addr_d;
  logic all_ready_q, all_ready_d;
  logic all_over_q, all_over_d;
  logic [`ADSR_AXES-1:0] seen_q, seen_d;
  logic [7:0] evsrc_q, evsrc_d;
  logic [2:0] cond_prev_q, cond_prev_d;
  logic active_prev_q;
  logic [1:0] opstate_q;
  logic low_rate_q;
  logic pending_q;

  logic start;
  logic rd_fire;
  logic [`ADSR_AXES-1:0] high_read;
  logic [`ADSR_AXES-1:0] new_sample;
  logic [`ADSR_AXES-1:0] ready;
  logic [`ADSR_AXES-1:0] overwrite;
  logic [`ADSR_AXES-1:0] overrun;
  logic [7:0] high_byte [`ADSR_AXES];
  logic [7:0] low_byte [`ADSR_AXES];
  logic [`ADSR_SAMPLE_W-1:0] sample_in [`ADSR_AXES];
  logic all_highs_read;
  logic [2:0] cond;
  logic [7:0] ev_set;
  logic any_event;
  logic [1:0] mode;
  logic transition;
  logic sleeping;
  logic [7:0] status_byte;

  // next burst address from the current one
  function automatic logic [7:0] next_addr(input logic [7:0] a, input logic fast);
    logic [7:0] n;
    n = 8'(a + `ADSR_ADDR_STEP);
    if (a == `ADSR_ADDR_Z_LO) begin
      n = `ADSR_ADDR_STATUS;
    end else if (fast) begin
      unique case (a)
        `ADSR_ADDR_X_HI: n = `ADSR_ADDR_Y_HI;
        `ADSR_ADDR_Y_HI: n = `ADSR_ADDR_Z_HI;
        `ADSR_ADDR_Z_HI: n = `ADSR_ADDR_STATUS;
        `ADSR_ADDR_X_LO: n = `ADSR_ADDR_STATUS;
        `ADSR_ADDR_Y_LO: n = `ADSR_ADDR_STATUS;
        default: n = 8'(a + `ADSR_ADDR_STEP);
      endcase
    end
    return n;
  endfunction

  // address of the high byte of one axis
  function automatic logic [7:0] high_addr(input int axis);
    logic [7:0] h;
    h = `ADSR_ADDR_X_HI;
    if (axis == 1) begin
      h = `ADSR_ADDR_Y_HI;
    end else if (axis == 2) begin
      h = `ADSR_ADDR_Z_HI;
    end
    return h;
  endfunction

  // a read is taken unless an address load arrives in the same cycle
  assign rd_fire = rd_req && !addr_load;
  // standby-to-active start wipes sample, status and event contents
  assign start = active && !active_prev_q;
  assign sample_in[0] = x_sample;
  assign sample_in[1] = y_sample;
  assign sample_in[2] = z_sample;

  // one channel per axis; high read decode from the current pointer
  genvar g;
  generate
    for (g = 0; g < `ADSR_AXES; g++) begin : g_axis
      assign high_read[g] = rd_fire && (ptr_q == high_addr(g));
      assign new_sample[g] = sample_strobe[g] && active;
      adsr_axis u_axis (
        .clock(clock),
        .rst_n(rst_n),
        .clear(start),
        .new_sample(new_sample[g]),
        .sample_in(sample_in[g]),
        .high_read(high_read[g]),
        .high_byte(high_byte[g]),
        .low_byte(low_byte[g]),
        .ready(ready[g]),
        .overwrite(overwrite[g]),
        .overrun(overrun[g])
      );
    end
  endgenerate

  // operating state machine
  adsr_sleep #(
    .LIMIT_W(LIMIT_W)
  ) u_sleep (
    .clock(clock),
    .rst_n(rst_n),
    .active(active),
    .sleep_enable(sleep_enable),
    .inactivity_limit(inactivity_limit),
    .time_tick(time_tick),
    .any_event(any_event),
    .wake_event(wake_event),
    .mode(mode),
    .transition(transition),
    .low_rate(sleeping)
  );

  // all three high bytes read since the last new sample
  assign all_highs_read = ((seen_q | high_read) == `ADSR_ALL_AXES);

  // combined flags and the high-read tracker; a new sample wins
  always_comb begin
    all_ready_d = all_ready_q;
    all_over_d = all_over_q;
    seen_d = seen_q | high_read;
    if (all_highs_read) begin
      all_ready_d = 1'h0;
      all_over_d = 1'h0;
      seen_d = '0;
    end
    if (|new_sample) begin
      all_ready_d = 1'h1;
      seen_d = high_read & ~new_sample;
    end
    if (|overrun) begin
      all_over_d = 1'h1;
    end
    if (start) begin
      all_ready_d = 1'h0;
      all_over_d = 1'h0;
      seen_d = '0;
    end
  end

  // source conditions and their rising edges
  always_comb begin
    cond[0] = (all_ready_q || all_over_q) && drdy_enable;
    cond[1] = motion_active && motion_enable;
    cond[2] = orientation_changed && orient_enable;
    cond_prev_d = {cond[2:1], cond[0] && !all_highs_read}; // re-arm when highs read
    ev_set = 8'h00;
    ev_set[`ADSR_EV_DRDY] = cond[0] && !cond_prev_q[0];
    ev_set[`ADSR_EV_MOTION] = cond[1] && !cond_prev_q[1];
    ev_set[`ADSR_EV_ORIENT] = cond[2] && !cond_prev_q[2];
    ev_set[`ADSR_EV_SLEEP] = transition;
    any_event = |ev_set[`ADSR_EV_ORIENT:0];
  end

  // event-source bits: cleared by reading the tied register, set wins
  always_comb begin
    evsrc_d = evsrc_q;
    if (all_highs_read) begin
      evsrc_d[`ADSR_EV_DRDY] = 1'h0;
    end
    if (rd_fire && ptr_q == `ADSR_ADDR_MOTION_SRC) begin
      evsrc_d[`ADSR_EV_MOTION] = 1'h0;
    end
    if (rd_fire && ptr_q == `ADSR_ADDR_ORIENT_ST) begin
      evsrc_d[`ADSR_EV_ORIENT] = 1'h0;
    end
    if (rd_fire && ptr_q == `ADSR_ADDR_OPSTATE) begin
      evsrc_d[`ADSR_EV_SLEEP] = 1'h0;
    end
    evsrc_d = evsrc_d | ev_set;
    if (start) begin
      evsrc_d = 8'h00;
    end
  end

  // status byte: overwrite bits above ready bits, z y x order
  assign status_byte = {all_over_q, overwrite[2], overwrite[1], overwrite[0],
                        all_ready_q, ready[2], ready[1], ready[0]};

  // address pointer and read data
  always_comb begin
    ptr_d = ptr_q;
    rd_data_d = rd_data_q;
    rd_valid_d = rd_fire;
    rd_addr_d = rd_addr_q;
    if (addr_load) begin
      ptr_d = addr_in;
    end else if (rd_req || wr_req) begin
      ptr_d = next_addr(ptr_q, fast_read);
    end
    if (rd_fire) begin
      rd_addr_d = ptr_q;
      unique case (ptr_q)
        `ADSR_ADDR_STATUS: rd_data_d = status_byte;
        `ADSR_ADDR_X_HI: rd_data_d = high_byte[0];
        `ADSR_ADDR_X_LO: rd_data_d = low_byte[0];
        `ADSR_ADDR_Y_HI: rd_data_d = high_byte[1];
        `ADSR_ADDR_Y_LO: rd_data_d = low_byte[1];
        `ADSR_ADDR_Z_HI: rd_data_d = high_byte[2];
        `ADSR_ADDR_Z_LO: rd_data_d = low_byte[2];
        `ADSR_ADDR_OPSTATE: rd_data_d = {6'h00, opstate_q};
        `ADSR_ADDR_EVSRC: rd_data_d = evsrc_q;
        `ADSR_ADDR_PART_ID: rd_data_d = `ADSR_PART_ID;
        default: rd_data_d = ext_rd_data;
      endcase
    end
  end

  // register the bank state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= `ADSR_ADDR_STATUS;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'h0;
      rd_addr_q <= `ADSR_ADDR_STATUS;
      all_ready_q <= 1'h0;
      all_over_q <= 1'h0;
      seen_q <= '0;
      evsrc_q <= 8'h00;
      cond_prev_q <= 3'h0;
      active_prev_q <= 1'h0;
      opstate_q <= `ADSR_MODE_STANDBY;
      low_rate_q <= 1'h0;
      pending_q <= 1'h0;
    end else begin
      ptr_q <= ptr_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      rd_addr_q <= rd_addr_d;
      all_ready_q <= all_ready_d;
      all_over_q <= all_over_d;
      seen_q <= seen_d;
      evsrc_q <= evsrc_d;
      cond_prev_q <= cond_prev_d;
      active_prev_q <= active;
      opstate_q <= mode;
      low_rate_q <= sleeping;
      pending_q <= |evsrc_d;
    end
  end

  // outputs straight from flops
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign rd_addr = rd_addr_q;
  assign operating_state = opstate_q;
  assign low_rate = low_rate_q;
  assign event_pending = pending_q;
endmodule // adsr_regs
`default_nettype wire

/* File: sim/adsr_regs_properties.sv */
// checker for the data/status register bank, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "adsr_params.svh"
module adsr_regs_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic active,
  input wire logic fast_read,
  input wire logic drdy_enable,
  input wire logic motion_enable,
  input wire logic orient_enable,
  input wire logic [2:0] sample_strobe,
  input wire logic orientation_changed,
  input wire logic motion_active,
  input wire logic addr_load,
  input wire logic rd_req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic [7:0] rd_addr,
  input wire logic [1:0] operating_state,
  input wire logic event_pending
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // a read taken, and two reads back to back
  sequence s_rd; rd_req && !addr_load; endsequence
  sequence s_next(logic f, logic [7:0] a);
    s_rd ##1 (s_rd and (fast_read == f && rd_addr == a));
  endsequence
  property p_answer; s_rd |=> rd_valid; endproperty
  property p_lone; !(rd_req && !addr_load) |=> !rd_valid; endproperty
  property p_fast; s_next(1'b1, 8'h01) |=> rd_addr == 8'h03; endproperty
  property p_normal; s_next(1'b0, 8'h01) |=> rd_addr == 8'h02; endproperty
  property p_wrap; s_next(1'b0, 8'h06) or s_next(1'b1, 8'h05) |=> rd_addr == 8'h00; endproperty
  property p_pad; rd_valid && rd_addr inside {8'h02, 8'h04, 8'h06} |-> rd_data[5:0] == 6'h00;
  endproperty
  property p_opstate; rd_valid && rd_addr == `ADSR_ADDR_OPSTATE |->
    rd_data[7:2] == 6'h00 && rd_data[1:0] != 2'h3; endproperty
  property p_evsrc; rd_valid && rd_addr == `ADSR_ADDR_EVSRC |-> (rd_data & 8'h6A) == 8'h00;
  endproperty
  property p_id; rd_valid && rd_addr == `ADSR_ADDR_PART_ID |-> rd_data == `ADSR_PART_ID;
  endproperty
  property p_standby; !active [*2] |=> operating_state == `ADSR_MODE_STANDBY; endproperty
  property p_drdy; active && $past(active) && drdy_enable && |sample_strobe |->
    ##[1:4] event_pending; endproperty
  property p_motion; $rose(motion_active) && motion_enable && active && $past(active) |->
    ##[1:3] event_pending; endproperty
  property p_orient; $rose(orientation_changed) && orient_enable && active && $past(active) |->
    ##[1:3] event_pending; endproperty
  a_answer: assert property (p_answer)
    else $error("read not answered in the next cycle");
  a_lone: assert property (p_lone)
    else $error("read answer without a read");
  a_fast: assert property (p_fast)
    else $error("fast burst did not skip the low byte");
  a_normal: assert property (p_normal)
    else $error("normal burst skipped the low byte");
  a_wrap: assert property (p_wrap)
    else $error("burst did not wrap to status");
  a_pad: assert property (p_pad)
    else $error("low byte padding not zero");
  a_opstate: assert property (p_opstate)
    else $error("operating state byte malformed");
  a_evsrc: assert property (p_evsrc)
    else $error("unused event source bits set");
  a_id: assert property (p_id)
    else $error("wrong identifier");
  a_standby: assert property (p_standby)
    else $error("not standby while inactive");
  a_drdy: assert property (p_drdy)
    else $error("sample ready event missing");
  a_motion: assert property (p_motion)
    else $error("motion event missing");
  a_orient: assert property (p_orient)
    else $error("orientation event missing");
endmodule // adsr_regs_properties
bind adsr_regs adsr_regs_properties i_adsr_regs_properties (.clock(clock), .rst_n(rst_n),
  .active(active), .fast_read(fast_read), .drdy_enable(drdy_enable),
  .motion_enable(motion_enable), .orient_enable(orient_enable),
  .sample_strobe(sample_strobe), .orientation_changed(orientation_changed),
  .motion_active(motion_active), .addr_load(addr_load), .rd_req(rd_req), .rd_data(rd_data),
  .rd_valid(rd_valid), .rd_addr(rd_addr), .operating_state(operating_state),
  .event_pending(event_pending));
`default_nettype wire

/* File: sim/adsr_host_model.sv */
// serial engine side model: loads the pointer and issues byte reads
`timescale 1ns/1ps
`default_nettype none
module adsr_host_model #(
  parameter logic [7:0] EXT_BYTE = 8'hA5
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output var logic addr_load,
  output var logic [7:0] addr_in,
  output var logic rd_req,
  output var logic wr_req,
  output var logic [7:0] ext_rd_data
);
  logic [7:0] got[$];
  // idle request lines, fixed answer for registers owned elsewhere
  initial begin
    addr_load = 1'b0;
    addr_in = 8'h00;
    rd_req = 1'b0;
    wr_req = 1'b0;
    ext_rd_data = EXT_BYTE;
  end
  // keep each returned byte once it has settled
  always @(negedge clock) begin
    if (rst_n && rd_valid === 1'b1) begin
      got.push_back(rd_data);
    end
  end
  // low bytes only reached by continuing straight after their high byte
  task automatic rd(input logic [7:0] a, input int n, input logic cont);
    got.delete();
    if (!cont) begin
      @(posedge clock) #1 addr_load = 1'b1;
      addr_in = a;
    end
    @(posedge clock) #1 addr_load = 1'b0;
    rd_req = 1'b1;
    repeat (n) @(posedge clock);
    #1 rd_req = 1'b0;
    @(posedge clock) #1;
  endtask
  // one write, whose data the bank ignores
  task automatic wr(input logic [7:0] a);
    @(posedge clock) #1 addr_load = 1'b1;
    addr_in = a;
    @(posedge clock) #1 addr_load = 1'b0;
    wr_req = 1'b1;
    @(posedge clock) #1 wr_req = 1'b0;
  endtask
endmodule // adsr_host_model
`default_nettype wire

/* File: sim/test_adsr_regs.sv */
// self-checking bench for the data/status register bank
`timescale 1ns/1ps
`default_nettype none
`include "adsr_params.svh"
`define CHK(what, exp, got) \
  compares++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("BAD %s expected %h seen %h", what, exp, got); \
  end
module test_adsr_regs;
  typedef struct {logic fast; logic twice; logic [9:0] x, y, z; logic [7:0] st;} adsr_row_t;
  logic clock, rst_n, active, fast_read, sleep_enable, drdy_enable, motion_enable;
  logic orient_enable, time_tick, wake_event, orientation_changed, motion_active;
  logic addr_load, rd_req, wr_req, rd_valid, low_rate, event_pending;
  logic [7:0] inactivity_limit, addr_in, ext_rd_data, rd_data, rd_addr;
  logic [2:0] sample_strobe;
  logic [9:0] x_sample, y_sample, z_sample;
  logic [1:0] operating_state;
  logic [7:0] exp_q[$];
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  adsr_row_t rows[4] = '{'{1'b0, 1'b0, 10'h155, 10'h2AA, 10'h3FF, 8'h0F},
    '{1'b1, 1'b0, 10'h200, 10'h1FF, 10'h001, 8'h0F},
    '{1'b0, 1'b1, 10'h0C3, 10'h301, 10'h07E, 8'hFF},
    '{1'b1, 1'b1, 10'h3FE, 10'h002, 10'h180, 8'hFF}};
  adsr_regs i_adsr_regs (.clock(clock), .rst_n(rst_n), .active(active), .fast_read(fast_read),
    .sleep_enable(sleep_enable), .inactivity_limit(inactivity_limit),
    .drdy_enable(drdy_enable), .motion_enable(motion_enable), .orient_enable(orient_enable),
    .time_tick(time_tick), .wake_event(wake_event), .sample_strobe(sample_strobe),
    .x_sample(x_sample), .y_sample(y_sample), .z_sample(z_sample),
    .orientation_changed(orientation_changed), .motion_active(motion_active),
    .addr_load(addr_load), .addr_in(addr_in), .rd_req(rd_req), .wr_req(wr_req),
    .ext_rd_data(ext_rd_data), .rd_data(rd_data), .rd_valid(rd_valid), .rd_addr(rd_addr),
    .operating_state(operating_state), .low_rate(low_rate), .event_pending(event_pending));
  adsr_host_model i_adsr_host_model (.clock(clock), .rst_n(rst_n), .rd_valid(rd_valid),
    .rd_data(rd_data), .addr_load(addr_load), .addr_in(addr_in), .rd_req(rd_req),
    .wr_req(wr_req), .ext_rd_data(ext_rd_data));
  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // cycle limit cuts a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("BAD cycle limit expected %0d seen %0d", 2999, cycles);
      wrap_up();
    end
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic pulse_in(ref logic s);
    @(posedge clock) #1 s = 1'b1;
    @(posedge clock) #1 s = 1'b0;
  endtask
  task automatic strobe(input logic [2:0] m, input logic twice);
    repeat (twice ? 2 : 1) begin
      @(posedge clock) #1 sample_strobe = m;
      @(posedge clock) #1 sample_strobe = 3'h0;
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input logic cont);
    i_adsr_host_model.rd(a, 1, cont);
    `CHK("read byte", e, i_adsr_host_model.got[0])
    `CHK("read address", a, rd_addr)
  endtask
  task automatic wrap_up();
    $display("counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    adsr_row_t r;
    {rst_n, active, fast_read, sleep_enable, time_tick, wake_event} = 6'h00;
    {drdy_enable, motion_enable, orient_enable} = 3'h7;
    {orientation_changed, motion_active, sample_strobe} = 5'h00;
    {x_sample, y_sample, z_sample} = 30'h0;
    inactivity_limit = 8'h02;
    idle(20);
    rst_n = 1'b1;
    `CHK("state after reset", 2'h0, operating_state)
    `CHK("pending after reset", 1'b0, event_pending)
    chk_rd(`ADSR_ADDR_PART_ID, `ADSR_PART_ID, 1'b0);
    i_adsr_host_model.wr(`ADSR_ADDR_PART_ID);
    chk_rd(`ADSR_ADDR_PART_ID, `ADSR_PART_ID, 1'b0);
    chk_rd(`ADSR_ADDR_OPSTATE, 8'h00, 1'b0);
    chk_rd(`ADSR_ADDR_EVSRC, 8'h00, 1'b0);
    $display("test reset done");
    active = 1'b1;
    idle(3);
    chk_rd(`ADSR_ADDR_OPSTATE, 8'h01, 1'b0);
    // ordinary bursts, normal and fast, fresh and overrun
    foreach (rows[i]) begin
      r = rows[i];
      fast_read = r.fast;
      {x_sample, y_sample, z_sample} = {r.x, r.y, r.z};
      strobe(3'h7, r.twice);
      if (r.fast) begin
        exp_q = '{r.st, r.x[9:2], r.y[9:2], r.z[9:2], 8'h00};
      end else begin
        exp_q = '{r.st, r.x[9:2], {r.x[1:0], 6'h00}, r.y[9:2], {r.y[1:0], 6'h00},
          r.z[9:2], {r.z[1:0], 6'h00}, 8'h00};
      end
      i_adsr_host_model.rd(`ADSR_ADDR_STATUS, exp_q.size(), 1'b0);
      `CHK("burst length", exp_q.size(), i_adsr_host_model.got.size())
      foreach (exp_q[k]) begin
        `CHK("burst byte", exp_q[k], i_adsr_host_model.got[k])
      end
    end
    $display("test rows done");
    // new sample between high and low read
    fast_read = 1'b0;
    x_sample = 10'h2C5;
    strobe(3'h1, 1'b0);
    chk_rd(`ADSR_ADDR_X_HI, 8'hB1, 1'b0);
    x_sample = 10'h13A;
    strobe(3'h1, 1'b0);
    chk_rd(`ADSR_ADDR_X_LO, 8'h40, 1'b1);
    chk_rd(`ADSR_ADDR_STATUS, 8'h09, 1'b0);
    i_adsr_host_model.rd(`ADSR_ADDR_X_HI, 6, 1'b0);
    $display("test capture done");
    // event source set and cleared through the owning registers
    strobe(3'h7, 1'b0);
    chk_rd(`ADSR_ADDR_STATUS, 8'h0F, 1'b0);
    chk_rd(`ADSR_ADDR_EVSRC, 8'h01, 1'b0);
    i_adsr_host_model.rd(`ADSR_ADDR_X_HI, 6, 1'b0);
    chk_rd(`ADSR_ADDR_EVSRC, 8'h00, 1'b0);
    {motion_active, orientation_changed} = 2'h3;
    idle(3);
    chk_rd(`ADSR_ADDR_EVSRC, 8'h14, 1'b0);
    chk_rd(`ADSR_ADDR_MOTION_SRC, 8'hA5, 1'b0);
    chk_rd(`ADSR_ADDR_EVSRC, 8'h10, 1'b0);
    chk_rd(`ADSR_ADDR_ORIENT_ST, 8'hA5, 1'b0);
    chk_rd(`ADSR_ADDR_EVSRC, 8'h00, 1'b0);
    {motion_active, orientation_changed} = 2'h0;
    $display("test events done");
    // inactivity sleep and wake
    sleep_enable = 1'b1;
    repeat (4) pulse_in(time_tick);
    idle(3);
    chk_rd(`ADSR_ADDR_EVSRC, 8'h80, 1'b0);
    chk_rd(`ADSR_ADDR_OPSTATE, 8'h02, 1'b0);
    `CHK("low rate in sleep", 1'b1, low_rate)
    chk_rd(`ADSR_ADDR_EVSRC, 8'h00, 1'b0);
    pulse_in(wake_event);
    idle(3);
    chk_rd(`ADSR_ADDR_EVSRC, 8'h80, 1'b0);
    chk_rd(`ADSR_ADDR_OPSTATE, 8'h01, 1'b0);
    `CHK("low rate in wake", 1'b0, low_rate)
    sleep_enable = 1'b0;
    $display("test sleep done");
    // standby keeps data, restart clears it
    active = 1'b0;
    idle(3);
    `CHK("standby state", 2'h0, operating_state)
    chk_rd(`ADSR_ADDR_X_HI, x_sample[9:2], 1'b0);
    active = 1'b1;
    idle(3);
    chk_rd(`ADSR_ADDR_STATUS, 8'h00, 1'b0);
    chk_rd(`ADSR_ADDR_X_HI, 8'h00, 1'b0);
    chk_rd(`ADSR_ADDR_EVSRC, 8'h00, 1'b0);
    $display("test restart done");
    wrap_up();
  end
endmodule // test_adsr_regs
`default_nettype wire
